// File: verification/motor_protection_monitor_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
	begin \
		n_checks++; \
		if ((got) !== (ex)) \
		begin \
			n_errors++; \
			$display("Error %s expected %h seen %h", nm, ex, got); \
		end \
	end
module motor_protection_monitor_test;
	import mpm_pkg::*;
	localparam int TK = 10;
	localparam logic [7:0] RA [9] = '{8'h40, 8'h44, 8'h48, 8'h50, 8'h54, 8'h58, 8'h08, 8'h04, 8'h00};
	localparam logic [31:0] RV [9] = '{32'(R_LIM), 32'(R_TLV), 32'(R_TDL), 32'h14, R_EHL, R_ELL,
		32'(R_BRK), 32'h0, 32'h0};
	localparam logic [8:0] SC [5] = '{9'h102, 9'h104, 9'h106, 9'h028, 9'h068};
	localparam int SN [5] = '{250, 500, 1000, 250, 250};
	localparam logic [31:0] SW [5] = '{32'h02580400, 32'h02580400, 32'h02580400, 32'h02580400,
		32'h03e82400};
	localparam logic [31:0] SB [5] = '{32'h0c00, 32'h0c00, 32'h0c00, 32'h1400, 32'h1400};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	mpm_meas_t meas [NCH];
	mpm_sup_t sup [NCH];
	logic [NCH-1:0] brake, stuck;
	logic [7:0] act [NCH];
	logic signed [15:0] cmd [NCH];
	logic [15:0] amps [NCH];
	int n_errors = 0;
	int n_checks = 0;
	int seed = 11;
	logic [33:0] rd_q [$];
	logic [9:0] act_q [$];
	logic [33:0] e;
	logic [9:0] ea;

	mpm_monitor #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .meas_i(meas), .sup_o(sup), .brake_o(brake),
		.action_o(act), .irq_o(irq));
	mpm_plant u_plant (.pclk(pclk), .presetn(presetn), .cmd(cmd), .amps(amps), .stuck(stuck),
		.sup(sup), .meas(meas));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic close_out;
		// Expected results that never showed up count as mismatches
		n_errors += rd_q.size() + act_q.size();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16)
		begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1)
		begin
			n_errors++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Expected word is {irq, slave error, read data}
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		rd_q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic tk(input int n);
		repeat (n * TK) @(posedge pclk);
	endtask

	// Sampled at the edge that ends the access, before that edge's updates land
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			e = rd_q.pop_front();
			`CHK("read", e, {irq, pslverr, prdata})
		end
		for (int k = 0; k < NCH; k++)
			if (act[k] !== 8'h00)
			begin
				ea = act_q.pop_front();
				`CHK("action", ea, {2'(k), act[k]})
			end
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, stuck} = '0;
		cmd = '{default: 16'sh0};
		amps = '{default: 16'h0};
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 9; i++)
			rd(RA[i], {2'b00, RV[i]});
		rd(8'h3c, {2'b01, 32'h0});
		wr(8'h40, 32'h5);
		rd(8'h40, {18'h0, LVL_MIN});
		wr(8'h48, 32'h4e20);
		rd(8'h48, {18'h0, TDL_MAX});
		wr(8'h40, 32'(R_LIM));
		for (int c = 1; c <= NCH; c++)
			wr(8'(c * 64 + 16), 32'h0);
		wr(A_BRK, 32'd20);
		wr(A_MASK, 32'h10);
		$display("test registers done");
		wr(8'h54, 32'd40);
		wr(8'h5c, 32'h13);
		act_q.push_back({2'd0, 8'h04});
		cmd[0] <= 16'sd1000;
		tk(10);
		`CHK("desired_hi", 32'd40, sup[0].desired)
		amps[0] <= 16'd800;
		tk(8);
		`CHK("scale_cut", 1'b1, sup[0].scale < SCALE_FULL)
		`CHK("power_cut", 1'b1, $signed(sup[0].power) < 16'sd1000)
		amps[0] <= 16'd0;
		tk(80);
		`CHK("scale_back", SCALE_FULL, sup[0].scale)
		cmd[0] <= 16'sd0;
		tk(10);
		`CHK("brake_hold", 1'b1, brake[0])
		tk(15);
		`CHK("brake_drop", 1'b0, brake[0])
		cmd[0] <= -16'sd1000;
		tk(1);
		`CHK("desired_lo", R_ELL, sup[0].desired)
		cmd[0] <= 16'sd0;
		$display("test limits done");
		wr(8'h84, 32'd100);
		wr(8'h88, 32'd3);
		for (int k = 1; k <= 9; k++)
		begin
			wr(8'h8c, 32'(k == 9 ? 3 : k + 32));
			// Two short spikes add up past the delay only if the timer fails to restart
			repeat (2)
			begin
				amps[1] <= 16'd150 + 16'($random(seed) & 63);
				repeat (5 + ($random(seed) & 7)) @(posedge pclk);
				amps[1] <= 16'd0;
				tk(2);
			end
			if (k < 9)
				act_q.push_back({2'd1, 8'(1 << (k - 1))});
			amps[1] <= 16'd150;
			tk(6);
			amps[1] <= 16'd0;
			tk(2);
		end
		rd(A_STAT, {2'b10, 32'h18});
		wr(A_MASK, 32'h0);
		rd(A_STAT, {2'b00, 32'h18});
		wr(A_STAT, 32'h10);
		wr(A_MASK, 32'h10);
		rd(A_STAT, {2'b00, 32'h08});
		$display("test trigger done");
		stuck <= 3'b100;
		for (int j = 0; j < 5; j++)
		begin
			wr(8'hd0, 32'(SC[j]));
			cmd[2] <= (j == 4) ? 16'sd1000 : 16'sd600;
			tk(SN[j] - 20);
			rd(8'he0, {2'b00, SW[j]});
			`CHK("brake_on", 1'b1, brake[2])
			tk(30);
			rd(8'he0, {2'b00, SB[j]});
			tk(15);
			`CHK("brake_off", 1'b0, brake[2])
			cmd[2] <= 16'sd0;
			tk(3);
			rd(8'he0, {2'b00, 32'h400});
		end
		$display("test stall done");
		close_out();
	end
endmodule // motor_protection_monitor_test

// File: verification/mpm_monitor_assertions.sv
`timescale 1ns/1ns
module mpm_monitor_assertions #(
	parameter int TICK_CYCLES = 10
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Motor side
	input mpm_pkg::mpm_meas_t meas_i [mpm_pkg::NCH],
	input mpm_pkg::mpm_sup_t sup_o [mpm_pkg::NCH],
	input wire logic [mpm_pkg::NCH-1:0] brake_o,
	input wire logic [7:0] action_o [mpm_pkg::NCH]
);
	import mpm_pkg::*;
	logic any_ev;
	always_comb
	begin
		any_ev = 1'b0;
		for (int k = 0; k < NCH; k++)
			any_ev = any_ev | sup_o[k].ev[EV_TRIG] | sup_o[k].ev[EV_HLIM];
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	for (genvar i = 0; i < NCH; i++)
	begin : g_ch
		property p_scale_step;
			$changed(sup_o[i].scale) |-> sup_o[i].scale == $past(sup_o[i].scale) + SCALE_STEP
				|| sup_o[i].scale + SCALE_STEP == $past(sup_o[i].scale);
		endproperty
		a_scale_step: assert property (p_scale_step)
			else $error("scale moved by other than one step");
		property p_act_onehot;
			$onehot0(action_o[i]);
		endproperty
		a_act_onehot: assert property (p_act_onehot)
			else $error("action pulse carries several codes");
		property p_act_cause;
			action_o[i] != 8'h00 |-> $past(any_ev);
		endproperty
		a_act_cause: assert property (p_act_cause)
			else $error("action pulse without an event");
		property p_trig_pulse;
			sup_o[i].ev[EV_TRIG] |=> !sup_o[i].ev[EV_TRIG];
		endproperty
		a_trig_pulse: assert property (p_trig_pulse)
			else $error("trigger event longer than one cycle");
		property p_stall_cut;
			sup_o[i].stalled [*3] |-> sup_o[i].power == 16'sh0;
		endproperty
		a_stall_cut: assert property (p_stall_cut)
			else $error("power not cut while stalled");
		// Release must follow a zero command, never a timeout
		property p_stall_hold;
			$fell(sup_o[i].stalled) |-> $past(meas_i[i].command) == 16'sh0
				|| $past(meas_i[i].command, 2) == 16'sh0;
		endproperty
		a_stall_hold: assert property (p_stall_hold)
			else $error("stall released without zero command");
		property p_loop_cut;
			sup_o[i].loop_fault [*3] |-> sup_o[i].power == 16'sh0;
		endproperty
		a_loop_cut: assert property (p_loop_cut)
			else $error("power not cut on loop fault");
		property p_brake_on;
			sup_o[i].power != 16'sh0 |-> ##[0:1] brake_o[i];
		endproperty
		a_brake_on: assert property (p_brake_on)
			else $error("brake applied while driving");
		property p_freeze;
			sup_o[i].freeze |-> $signed(sup_o[i].power) >= 16'sd1000
				|| $signed(sup_o[i].power) <= -16'sd1000;
		endproperty
		a_freeze: assert property (p_freeze)
			else $error("setpoint frozen below full power");
	end
endmodule // mpm_monitor_assertions

bind mpm_monitor mpm_monitor_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_mpm_chk (
	.pclk(pclk),
	.presetn(presetn),
	.meas_i(meas_i),
	.sup_o(sup_o),
	.brake_o(brake_o),
	.action_o(action_o)
);

// File: verification/mpm_plant.sv
`timescale 1ns/1ns
module mpm_plant (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench controls
	input wire logic signed [15:0] cmd [mpm_pkg::NCH],
	input wire logic [15:0] amps [mpm_pkg::NCH],
	input wire logic [mpm_pkg::NCH-1:0] stuck,
	// Block side
	input mpm_pkg::mpm_sup_t sup [mpm_pkg::NCH],
	output mpm_pkg::mpm_meas_t meas [mpm_pkg::NCH]
);
	import mpm_pkg::*;
	logic signed [31:0] cnt_q [NCH];
	for (genvar i = 0; i < NCH; i++)
	begin : g_ch
		// One count per driven cycle keeps counters far below the default soft limit
		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
				cnt_q[i] <= '0;
			else if (!stuck[i] && sup[i].power != 16'sh0)
				cnt_q[i] <= cnt_q[i] + ($signed(sup[i].power) > 0 ? 32'sd1 : -32'sd1);
		assign meas[i] = '{current: amps[i], command: cmd[i], power: cmd[i],
			fb_other: cnt_q[i][15:0], fb_bl: cnt_q[i][15:0], count_enc: cnt_q[i],
			count_bl: cnt_q[i]};
	end
endmodule // mpm_plant

// File: verilog/mpm_chan.sv
`timescale 1ns/1ns
module mpm_chan (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	// Settings and measurements
	input mpm_pkg::mpm_cfg_t cfg,
	input mpm_pkg::mpm_meas_t meas,
	// Results
	output mpm_pkg::mpm_sup_t sup
);
	import mpm_pkg::*;

	logic [11:0] scale_q, scale_d;
	logic [13:0] tcnt_q, scnt_q, lcnt_q;
	logic tdone_q, stall_q, lerr_q, hl_q, trig_q;
	logic [31:0] last_q;
	logic signed [15:0] pwr_q;
	logic [3:0] ev_q;
	logic signed [31:0] des_q;

	wire over_lim = meas.current > cfg.current_limit;
	wire over_trig = meas.current > cfg.current_trigger_level;
	wire signed [27:0] prod = 28'(meas.power * $signed({4'h0, scale_q}));
	wire signed [15:0] pwr_lim = prod[25:10];
	wire [15:0] pwr_mag = mpm_mag(17'(pwr_lim));
	wire [31:0] cnt_sel = cfg.feedback_source_select ? meas.count_bl : meas.count_enc;
	wire signed [15:0] fb_sel = cfg.feedback_source_select ? meas.fb_bl : meas.fb_other;
	wire [15:0] err_mag = mpm_mag(17'(meas.command) - 17'(fb_sel));

	// Stall figures: 250/500/1000 ms at 10/25/50 % of full power
	wire [13:0] st_time = (cfg.stall_detect_setting == 2'h1) ? 14'd250 :
		(cfg.stall_detect_setting == 2'h2) ? 14'd500 : 14'd1000;
	wire [15:0] st_pwr = (cfg.stall_detect_setting == 2'h1) ? 16'd100 :
		(cfg.stall_detect_setting == 2'h2) ? 16'd250 : 16'd500;
	// Loop error figures: 250/500/1000 ms above 100/250/500
	wire [13:0] le_time = (cfg.loop_error_detect_setting == 2'h1) ? 14'd250 :
		(cfg.loop_error_detect_setting == 2'h2) ? 14'd500 : 14'd1000;
	wire [15:0] le_lvl = (cfg.loop_error_detect_setting == 2'h1) ? 16'd100 :
		(cfg.loop_error_detect_setting == 2'h2) ? 16'd250 : 16'd500;

	wire st_scope = cfg.brushless || (cfg.mode == MPM_CL_SPEED && !cfg.feedback_source_select);
	wire st_qual = (cfg.stall_detect_setting != 2'h0) && st_scope && pwr_mag > st_pwr &&
		cnt_sel == last_q;
	wire le_qual = (cfg.loop_error_detect_setting != 2'h0) && err_mag > le_lvl;
	wire st_hit = tick && st_qual && scnt_q >= st_time - 14'd1;
	wire le_hit = tick && le_qual && lcnt_q >= le_time - 14'd1;
	wire tr_hit = tick && over_trig && !tdone_q && tcnt_q >= cfg.current_trigger_delay[13:0];
	wire above = $signed(meas.count_enc) > $signed(cfg.encoder_high_count_limit);

	// Back off in steps while over the limit, recover slowly once below
	always_comb
	begin
		scale_d = scale_q;
		if (tick && over_lim)
			scale_d = (scale_q > SCALE_STEP) ? scale_q - SCALE_STEP : 12'h000;
		else if (tick && scale_q < SCALE_FULL)
			scale_d = scale_q + SCALE_STEP;
	end

	// Relative position: -1000..+1000 spans low..high count limit
	wire signed [15:0] cmd_c = (meas.command > CMD_FULL) ? CMD_FULL :
		(meas.command < -CMD_FULL) ? -CMD_FULL : meas.command;
	wire signed [32:0] span = 33'($signed(cfg.encoder_high_count_limit)) -
		33'($signed(cfg.encoder_low_count_limit));
	wire signed [47:0] part = (48'(span) * 48'($signed(17'(cmd_c) + 17'sd1000))) / 48'sd2000;
	wire signed [31:0] des_d = $signed(cfg.encoder_low_count_limit) + part[31:0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scale_q <= SCALE_FULL;
			tcnt_q <= 14'h0000;
			scnt_q <= 14'h0000;
			lcnt_q <= 14'h0000;
			tdone_q <= 1'b0;
			stall_q <= 1'b0;
			lerr_q <= 1'b0;
			hl_q <= 1'b0;
			trig_q <= 1'b0;
			last_q <= 32'h00000000;
			pwr_q <= 16'sh0000;
			ev_q <= 4'h0;
			des_q <= 32'sh00000000;
		end
		else
		begin
			scale_q <= scale_d;
			trig_q <= tr_hit;
			if (!over_trig)
			begin
				tcnt_q <= 14'h0000;
				tdone_q <= 1'b0;
			end
			else if (tick && !tdone_q)
			begin
				tcnt_q <= tcnt_q + 14'h0001;
				tdone_q <= tr_hit;
			end
			if (tick)
			begin
				last_q <= cnt_sel;
				scnt_q <= st_qual ? scnt_q + 14'h0001 : 14'h0000;
				lcnt_q <= le_qual ? lcnt_q + 14'h0001 : 14'h0000;
			end
			// A new stall wins over the command-zero release
			stall_q <= st_hit | (stall_q & meas.command != 16'sh0000);
			lerr_q <= le_hit | (lerr_q & meas.command != 16'sh0000);
			hl_q <= above;
			pwr_q <= (stall_q | lerr_q) ? 16'sh0000 : pwr_lim;
			ev_q <= {above & ~hl_q, le_hit & ~lerr_q, st_hit & ~stall_q, tr_hit};
			des_q <= des_d;
		end
	end

	assign sup.power = pwr_q;
	assign sup.scale = scale_q;
	assign sup.stalled = stall_q;
	assign sup.loop_fault = lerr_q;
	// Hold the setpoint while the loop is saturated and already far behind
	assign sup.freeze = (cfg.mode == MPM_CNT_POS || cfg.mode == MPM_SPD_POS) &&
		cfg.loop_error_detect_setting != 2'h0 && err_mag > (le_lvl >> 1) &&
		mpm_mag(17'(pwr_q)) >= PWR_FULL;
	assign sup.ev = ev_q;
	assign sup.desired = des_q;
endmodule // mpm_chan

// File: verilog/mpm_monitor.sv
// Functional notes
// - Over current limit, keep cutting output power
// - Limit is 16-bit tenths amp, minimum 10
// - Action code bits 5:4 select target channel
// - Trigger fires after continuous over-level delay
// - Brake output drops after shared delay
// - Feedback select: 0 other, 1 brushless
// - Stalled counter under power cuts motor
// - Stall setting picks time and power
// - Stall watch: brushless, or encoder speed loop
// - Large loop error too long shuts down
// - Freeze setpoint when saturated and far behind
// - Counter above high limit fires action
// - Relative command 1000 maps to high limit
// - Relative command -1000 maps to low limit
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module mpm_monitor #(
	parameter int TICK_CYCLES = mpm_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Motor side
	input mpm_pkg::mpm_meas_t meas_i [mpm_pkg::NCH],
	output mpm_pkg::mpm_sup_t sup_o [mpm_pkg::NCH],
	output logic [mpm_pkg::NCH-1:0] brake_o,
	output logic [7:0] action_o [mpm_pkg::NCH],
	// Interrupt
	output logic irq_o
);
	import mpm_pkg::*;

	localparam int NEV = 4 * NCH;

	function automatic logic [15:0] lvl_clamp(input logic [15:0] v);
		lvl_clamp = (v < LVL_MIN) ? LVL_MIN : v;
	endfunction

	mpm_cfg_t cfg_q [NCH];
	mpm_sup_t sup [NCH];
	logic [NEV-1:0] stat_q, mask_q, ev_all;
	logic [15:0] brk_q;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [31:0] prdata_q;
	logic err_q;
	logic [15:0] bcnt_q [NCH];
	logic [7:0] act_q [NCH];

	// Bus decode
	wire setup = psel && !penable;
	wire wr = psel && penable && pwrite;
	wire [1:0] blk = paddr[7:6];
	wire [5:0] off = paddr[5:0];
	wire [1:0] ch = blk - 2'h1;
	wire glb = blk == 2'h0;
	wire glb_hit = glb && (paddr == A_STAT || paddr == A_MASK || paddr == A_BRK);
	wire ch_hit = !glb && off[1:0] == 2'h0 && off <= O_STS;
	wire hit = glb_hit || ch_hit;
	wire wr_stat = wr && paddr == A_STAT;
	wire wr_mask = wr && paddr == A_MASK;
	wire wr_brk = wr && paddr == A_BRK;

	// Read path
	wire mpm_cfg_t rc = cfg_q[ch];
	wire mpm_sup_t rs = sup[ch];
	wire [31:0] cfg_word = {23'h000000, rc.brushless, rc.mode,
		rc.loop_error_detect_setting, rc.stall_detect_setting, rc.feedback_source_select};
	wire [31:0] sts_word = {rs.power, 2'h0, rs.freeze, rs.loop_fault, rs.stalled,
		rs.scale[10:0]};
	wire [31:0] ch_rd = (off == O_LIM) ? {16'h0000, rc.current_limit} :
		(off == O_TLV) ? {16'h0000, rc.current_trigger_level} :
		(off == O_TDL) ? {16'h0000, rc.current_trigger_delay} :
		(off == O_TAC) ? {24'h000000, rc.current_trigger_action} :
		(off == O_CFG) ? cfg_word :
		(off == O_EHL) ? rc.encoder_high_count_limit :
		(off == O_ELL) ? rc.encoder_low_count_limit :
		(off == O_HAC) ? {24'h000000, rc.high_limit_action} :
		(off == O_STS) ? sts_word : 32'h00000000;
	wire [31:0] glb_rd = (paddr == A_STAT) ? {20'h00000, stat_q} :
		(paddr == A_MASK) ? {20'h00000, mask_q} :
		(paddr == A_BRK) ? {16'h0000, brk_q} : 32'h00000000;
	wire [31:0] rd_data = !hit ? 32'h00000000 : glb ? glb_rd : ch_rd;

	// Read data and error are latched in the setup cycle, so zero wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q <= rd_data;
			err_q <= !hit;
		end
	end

	assign prdata = prdata_q;
	assign pready = psel && penable;
	assign pslverr = psel && penable && err_q;

	// Millisecond tick, the control update rate for all timers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= tick_cnt_q == 32'(TICK_CYCLES - 1);
			tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h00000000 :
				tick_cnt_q + 32'h00000001;
		end
	end

	// Global registers; an event in the clearing cycle stays set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat_q <= '0;
			mask_q <= '0;
			brk_q <= R_BRK;
		end
		else
		begin
			stat_q <= (stat_q & ~(wr_stat ? pwdata[NEV-1:0] : '0)) | ev_all;
			if (wr_mask)
				mask_q <= pwdata[NEV-1:0];
			if (wr_brk)
				brk_q <= pwdata[15:0];
		end
	end

	assign irq_o = |(stat_q & mask_q);

	genvar c;
	generate
		for (c = 0; c < NCH; c++)
		begin : g_ch
			wire wr_c = wr && ch_hit && ch == 2'(c);
			wire energized = sup[c].power != 16'sh0000;
			logic [7:0] act_d;

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cfg_q[c] <= '{current_limit: R_LIM, current_trigger_level: R_TLV,
						current_trigger_delay: R_TDL, current_trigger_action: 8'h00,
						high_limit_action: 8'h00, feedback_source_select: 1'b0,
						stall_detect_setting: R_STALL, loop_error_detect_setting: R_LERR,
						mode: MPM_OPEN, brushless: 1'b0, encoder_high_count_limit: R_EHL,
						encoder_low_count_limit: R_ELL};
				end
				else if (wr_c)
				begin
					case (off)
						O_LIM: cfg_q[c].current_limit <= lvl_clamp(pwdata[15:0]);
						O_TLV: cfg_q[c].current_trigger_level <= lvl_clamp(pwdata[15:0]);
						O_TDL: cfg_q[c].current_trigger_delay <=
							(pwdata[15:0] > TDL_MAX) ? TDL_MAX : pwdata[15:0];
						O_TAC: cfg_q[c].current_trigger_action <= pwdata[7:0];
						O_CFG:
						begin
							cfg_q[c].feedback_source_select <= pwdata[F_FBSEL];
							cfg_q[c].stall_detect_setting <= pwdata[F_STALL+:2];
							cfg_q[c].loop_error_detect_setting <= pwdata[F_LERR+:2];
							cfg_q[c].mode <= mpm_mode_t'(pwdata[F_MODE+:3]);
							cfg_q[c].brushless <= pwdata[F_BLDC];
						end
						O_EHL: cfg_q[c].encoder_high_count_limit <= pwdata;
						O_ELL: cfg_q[c].encoder_low_count_limit <= pwdata;
						O_HAC: cfg_q[c].high_limit_action <= pwdata[7:0];
						default: cfg_q[c] <= cfg_q[c];
					endcase
				end
			end

			mpm_chan u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.tick(tick_q),
				.cfg(cfg_q[c]),
				.meas(meas_i[c]),
				.sup(sup[c])
			);

			assign ev_all[4*c+:4] = sup[c].ev;
			assign sup_o[c] = sup[c];

			// Collect actions aimed at this channel from every source channel
			always_comb
			begin
				act_d = 8'h00;
				for (int s = 0; s < NCH; s++)
				begin
					if (sup[s].ev[EV_TRIG] && mpm_target(cfg_q[s].current_trigger_action)[c]
						&& cfg_q[s].current_trigger_action[3:0] != 4'h0
						&& cfg_q[s].current_trigger_action[3:0] <= 4'h8)
						act_d[3'(cfg_q[s].current_trigger_action[3:0] - 4'h1)] = 1'b1;
					if (sup[s].ev[EV_HLIM] && mpm_target(cfg_q[s].high_limit_action)[c]
						&& cfg_q[s].high_limit_action[3:0] != 4'h0
						&& cfg_q[s].high_limit_action[3:0] <= 4'h8)
						act_d[3'(cfg_q[s].high_limit_action[3:0] - 4'h1)] = 1'b1;
				end
			end

			// Brake stays released while driven and for the delay after
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					bcnt_q[c] <= 16'h0000;
					brake_o[c] <= 1'b0;
					act_q[c] <= 8'h00;
				end
				else
				begin
					act_q[c] <= act_d;
					if (energized)
					begin
						bcnt_q[c] <= 16'h0000;
						brake_o[c] <= 1'b1;
					end
					else if (brake_o[c] && bcnt_q[c] >= brk_q)
						brake_o[c] <= 1'b0;
					else if (brake_o[c] && tick_q)
						bcnt_q[c] <= bcnt_q[c] + 16'h0001;
				end
			end

			assign action_o[c] = act_q[c];
		end
	endgenerate
endmodule // mpm_monitor

// File: verilog/mpm_pkg.sv
package mpm_pkg;
	localparam int NCH = 3;
	localparam int CLK_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
	// Global register offsets
	localparam logic [7:0] A_STAT = 8'h00;
	localparam logic [7:0] A_MASK = 8'h04;
	localparam logic [7:0] A_BRK = 8'h08;
	// Channel n (0..2) block sits at (n + 1) * 8'h40
	localparam logic [5:0] O_LIM = 6'h00;
	localparam logic [5:0] O_TLV = 6'h04;
	localparam logic [5:0] O_TDL = 6'h08;
	localparam logic [5:0] O_TAC = 6'h0c;
	localparam logic [5:0] O_CFG = 6'h10;
	localparam logic [5:0] O_EHL = 6'h14;
	localparam logic [5:0] O_ELL = 6'h18;
	localparam logic [5:0] O_HAC = 6'h1c;
	localparam logic [5:0] O_STS = 6'h20;
	// Configuration word fields
	localparam int F_FBSEL = 0;
	localparam int F_STALL = 1;
	localparam int F_LERR = 3;
	localparam int F_MODE = 5;
	localparam int F_BLDC = 8;
	// Status event bits per channel, four per channel
	localparam int EV_TRIG = 0;
	localparam int EV_STALL = 1;
	localparam int EV_LERR = 2;
	localparam int EV_HLIM = 3;
	// Reset values
	localparam logic [15:0] R_LIM = 16'h02ee;
	localparam logic [15:0] R_TLV = 16'hffff;
	localparam logic [15:0] R_TDL = 16'h01f4;
	localparam logic [15:0] R_BRK = 16'h00fa;
	localparam logic [1:0] R_STALL = 2'h2;
	localparam logic [1:0] R_LERR = 2'h2;
	localparam logic [31:0] R_EHL = 32'h00004e20;
	localparam logic [31:0] R_ELL = 32'hffffb1e0;
	localparam logic [15:0] LVL_MIN = 16'h000a;
	localparam logic [15:0] TDL_MAX = 16'h2710;
	localparam logic signed [15:0] CMD_FULL = 16'sh03e8;
	localparam logic [15:0] PWR_FULL = 16'h03e8;
	localparam logic [11:0] SCALE_FULL = 12'h400;
	localparam logic [11:0] SCALE_STEP = 12'h010;

	typedef enum logic [2:0] {
		MPM_OPEN = 3'b000,
		MPM_CL_SPEED = 3'b001,
		MPM_REL_POS = 3'b010,
		MPM_CNT_POS = 3'b011,
		MPM_SPD_POS = 3'b100
	} mpm_mode_t;

	typedef struct packed {
		logic [15:0] current_limit;
		logic [15:0] current_trigger_level;
		logic [15:0] current_trigger_delay;
		logic [7:0] current_trigger_action;
		logic [7:0] high_limit_action;
		logic feedback_source_select;
		logic [1:0] stall_detect_setting;
		logic [1:0] loop_error_detect_setting;
		mpm_mode_t mode;
		logic brushless;
		logic [31:0] encoder_high_count_limit;
		logic [31:0] encoder_low_count_limit;
	} mpm_cfg_t;

	typedef struct packed {
		logic [15:0] current;
		logic signed [15:0] command;
		logic signed [15:0] power;
		logic signed [15:0] fb_other;
		logic signed [15:0] fb_bl;
		logic signed [31:0] count_enc;
		logic signed [31:0] count_bl;
	} mpm_meas_t;

	typedef struct packed {
		logic signed [15:0] power;
		logic [11:0] scale;
		logic stalled;
		logic loop_fault;
		logic freeze;
		logic [3:0] ev;
		logic signed [31:0] desired;
	} mpm_sup_t;

	// Target channel one-hot from bits 5:4 of an action code
	function automatic logic [2:0] mpm_target(input logic [7:0] code);
		case (code[5:4])
			2'h1: mpm_target = 3'b001;
			2'h2: mpm_target = 3'b010;
			2'h3: mpm_target = 3'b100;
			default: mpm_target = 3'b000;
		endcase
	endfunction

	function automatic logic [15:0] mpm_mag(input logic signed [16:0] v);
		logic [16:0] a;
		a = v[16] ? 17'(-v) : 17'(v);
		mpm_mag = (a[16]) ? 16'hffff : a[15:0];
	endfunction
endpackage
